//--- rtl/agcdb_top.sv
`timescale 1ns/10ps
`include "agcdb_defines.svh"

// Operation
// - right applied-gain register is read-only, resets zero, signed half-dB code.
// - left noise debounce bits 7..3, codes 0-7 give 0 to 32 ms.
// - noise debounce codes from 8 upward give multiples of 64 ms.
// - left signal debounce bits 2..0 give 0 to 32 ms in eight steps.
// - right noise debounce bits 7..3 map like the left channel.
// - right signal debounce bits 2..0 map like the left channel.
// - listed debounce times apply only with double-rate mode off.
// - flag bit 7 is one when left applied gain equals programmed gain.
// - flag bit 6 is one while the left converter is powered.
// - flag bit 5 is one while left signal is below the noise threshold.
// - flag bit 4 is one while left gain control sits at its limit.
// - flag bit 3 is one when right applied gain equals programmed gain.
// - flag bit 2 is one while the right converter is powered.
// - flag bit 1 is one while right signal is below the noise threshold.
// - flag bit 0 is one while right gain control sits at its limit.
// - a zero noise threshold turns off silence detection for that channel.
// - saturation compares with a half-dB maximum gain limit.

module agcdb_top #(
    parameter int HALF_MS_CYCLES = `AGCDB_HALF_MS_NS / `AGCDB_CLK_PERIOD_NS
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [`AGCDB_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [`AGCDB_DATA_W-1:0] reg_wdata_i,
    output logic [`AGCDB_DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic double_rate_audio_mode_i,
    input agcdb_pkg::agcdb_chan_s left_chan_i,
    input agcdb_pkg::agcdb_chan_s right_chan_i
);
    import agcdb_pkg::*;

    localparam int TICK_W = $clog2(HALF_MS_CYCLES);

    // ------------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------------
    if (HALF_MS_CYCLES < 4 || (HALF_MS_CYCLES % 2) != 0) begin : g_bad_param
        $error("half millisecond count must be even and at least four");
    end

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    logic [TICK_W-1:0] tick_cnt_ff;
    logic [TICK_W-1:0] tick_limit;
    logic tick;
    agcdb_dbnc_s left_dbnc_ff;
    agcdb_dbnc_s right_dbnc_ff;
    logic [7:0] right_gain_ff;
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic rvalid_ff;
    logic left_quiet;
    logic right_quiet;
    logic left_sat;
    logic right_sat;
    logic wr_left;
    logic wr_right;

    // ------------------------------------------------------------------------
    // half-millisecond tick; double-rate mode halves the period, so every
    // debounce time is half the listed value in that mode
    // ------------------------------------------------------------------------
    always_comb begin
        if (double_rate_audio_mode_i) begin
            tick_limit = TICK_W'(HALF_MS_CYCLES / 2 - 1);
        end else begin
            tick_limit = TICK_W'(HALF_MS_CYCLES - 1);
        end
    end

    assign tick = (tick_cnt_ff >= tick_limit);

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_cnt_ff <= '0;
        end else if (tick) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
        end
    end

    // ------------------------------------------------------------------------
    // debounce settings; writes to read-only or unmapped addresses are ignored
    // ------------------------------------------------------------------------
    assign wr_left = reg_wr_i && (reg_addr_i == `AGCDB_ADDR_LEFT_DBNC);
    assign wr_right = reg_wr_i && (reg_addr_i == `AGCDB_ADDR_RIGHT_DBNC);

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            left_dbnc_ff <= `AGCDB_RST_DBNC;
        end else if (wr_left) begin
            left_dbnc_ff.noise <= reg_wdata_i[`AGCDB_NOISE_MSB:`AGCDB_NOISE_LSB];
            left_dbnc_ff.sig <= reg_wdata_i[`AGCDB_SIG_MSB:`AGCDB_SIG_LSB];
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            right_dbnc_ff <= `AGCDB_RST_DBNC;
        end else if (wr_right) begin
            right_dbnc_ff.noise <= reg_wdata_i[`AGCDB_NOISE_MSB:`AGCDB_NOISE_LSB];
            right_dbnc_ff.sig <= reg_wdata_i[`AGCDB_SIG_MSB:`AGCDB_SIG_LSB];
        end
    end

    // ------------------------------------------------------------------------
    // silence detection per channel
    // ------------------------------------------------------------------------
    agcdb_debounce u_left_dbnc (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .tick_i(tick),
        .detect_en_i(left_chan_i.noise_thr != `AGCDB_THR_OFF),
        .quiet_i(left_chan_i.below_thr),
        .noise_code_i(left_dbnc_ff.noise),
        .sig_code_i(left_dbnc_ff.sig),
        .quiet_o(left_quiet)
    );

    agcdb_debounce u_right_dbnc (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .tick_i(tick),
        .detect_en_i(right_chan_i.noise_thr != `AGCDB_THR_OFF),
        .quiet_i(right_chan_i.below_thr),
        .noise_code_i(right_dbnc_ff.noise),
        .sig_code_i(right_dbnc_ff.sig),
        .quiet_o(right_quiet)
    );

    // ------------------------------------------------------------------------
    // live status, sampled every cycle so a read never sees a stale value
    // ------------------------------------------------------------------------
    assign left_sat = agcdb_saturated(left_chan_i.agc_gain, left_chan_i.max_gain);
    assign right_sat = agcdb_saturated(right_chan_i.agc_gain, right_chan_i.max_gain);

    always_comb begin
        nxt_flags = `AGCDB_RST_FLAGS;
        nxt_flags[`AGCDB_FLAG_L_PGA] = left_chan_i.pga_applied == left_chan_i.pga_prog;
        nxt_flags[`AGCDB_FLAG_L_PWR] = left_chan_i.adc_powered;
        nxt_flags[`AGCDB_FLAG_L_QUIET] = left_quiet;
        nxt_flags[`AGCDB_FLAG_L_SAT] = left_sat;
        nxt_flags[`AGCDB_FLAG_R_PGA] = right_chan_i.pga_applied == right_chan_i.pga_prog;
        nxt_flags[`AGCDB_FLAG_R_PWR] = right_chan_i.adc_powered;
        nxt_flags[`AGCDB_FLAG_R_QUIET] = right_quiet;
        nxt_flags[`AGCDB_FLAG_R_SAT] = right_sat;
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flags_ff <= `AGCDB_RST_FLAGS;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            right_gain_ff <= `AGCDB_RST_RIGHT_GAIN;
        end else begin
            right_gain_ff <= right_chan_i.agc_gain;
        end
    end

    // ------------------------------------------------------------------------
    // read path; reads only copy, nothing is cleared by them
    // ------------------------------------------------------------------------
    always_comb begin
        unique case (reg_addr_i)
            `AGCDB_ADDR_RIGHT_GAIN: nxt_rdata = right_gain_ff;
            `AGCDB_ADDR_LEFT_DBNC: nxt_rdata = left_dbnc_ff;
            `AGCDB_ADDR_RIGHT_DBNC: nxt_rdata = right_dbnc_ff;
            `AGCDB_ADDR_FLAGS: nxt_rdata = flags_ff;
            default: nxt_rdata = `AGCDB_RDATA_NONE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_ff <= `AGCDB_RDATA_NONE;
        end else if (reg_rd_i) begin
            rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd_i;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign reg_rvalid_o = rvalid_ff;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_rd(logic [6:0] a);
        reg_rd_i && (reg_addr_i == a);
    endsequence

    sequence s_wr_then_rd(logic [6:0] a);
        (reg_wr_i && (reg_addr_i == a)) ##1 (reg_rd_i && !reg_wr_i && (reg_addr_i == a));
    endsequence

    chk_gain_readback: assert property (
        s_rd(`AGCDB_ADDR_RIGHT_GAIN) |=> reg_rdata_o == $past(right_chan_i.agc_gain, 2))
        else $error("right gain readback differs from applied gain");

    chk_left_dbnc_store: assert property (
        s_wr_then_rd(`AGCDB_ADDR_LEFT_DBNC) |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("left debounce setting not stored");

    chk_right_dbnc_store: assert property (
        s_wr_then_rd(`AGCDB_ADDR_RIGHT_DBNC) |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("right debounce setting not stored");

    chk_gain_ro: assert property (
        reg_wr_i && (reg_addr_i == `AGCDB_ADDR_RIGHT_GAIN) |=>
        right_gain_ff == $past(right_chan_i.agc_gain))
        else $error("write reached the right gain readback");

    chk_pga_flags: assert property (
        s_rd(`AGCDB_ADDR_FLAGS) |=>
        reg_rdata_o[`AGCDB_FLAG_L_PGA] ==
        $past(left_chan_i.pga_applied == left_chan_i.pga_prog, 2) &&
        reg_rdata_o[`AGCDB_FLAG_R_PGA] ==
        $past(right_chan_i.pga_applied == right_chan_i.pga_prog, 2))
        else $error("gain settle flag wrong");

    chk_power_flags: assert property (
        s_rd(`AGCDB_ADDR_FLAGS) |=>
        reg_rdata_o[`AGCDB_FLAG_R_PWR] == $past(right_chan_i.adc_powered, 2) &&
        reg_rdata_o[`AGCDB_FLAG_L_PWR] == $past(left_chan_i.adc_powered, 2))
        else $error("converter power flag wrong");

    chk_sat_flags: assert property (
        s_rd(`AGCDB_ADDR_FLAGS) |=>
        reg_rdata_o[`AGCDB_FLAG_R_SAT] == $past(right_sat, 2) &&
        reg_rdata_o[`AGCDB_FLAG_L_SAT] == $past(left_sat, 2))
        else $error("saturation flag wrong");

    chk_thr_off: assert property (
        (right_chan_i.noise_thr == `AGCDB_THR_OFF) [*3] |-> !flags_ff[`AGCDB_FLAG_R_QUIET])
        else $error("silence flag set with detection off");

    chk_unmapped_rd: assert property (
        reg_rd_i && (reg_addr_i < `AGCDB_ADDR_RIGHT_GAIN || reg_addr_i > `AGCDB_ADDR_FLAGS)
        |=> reg_rdata_o == `AGCDB_RDATA_NONE && reg_rvalid_o)
        else $error("unmapped read returned data");

    chk_read_pure: assert property (
        reg_rd_i && !reg_wr_i |=> $stable(left_dbnc_ff) && $stable(right_dbnc_ff))
        else $error("read changed a setting");

    sequence s_idle;
        !reg_rd_i;
    endsequence

    chk_rvalid_pulse: assert property (
        1'h1 |=>
        reg_rvalid_o == $past(reg_rd_i))
        else $error("read valid off the strobe");

    chk_rdata_hold: assert property (
        s_idle |=>
        $stable(reg_rdata_o))
        else $error("read data moved without a read");

    chk_flags_wr_ignored: assert property (
        reg_wr_i && (reg_addr_i == `AGCDB_ADDR_FLAGS) |=>
        flags_ff[`AGCDB_FLAG_L_PWR] == $past(left_chan_i.adc_powered))
        else $error("left power flag wrong");

    chk_ro_settings: assert property (
        reg_wr_i && (reg_addr_i == `AGCDB_ADDR_RIGHT_GAIN) |=>
        $stable(left_dbnc_ff) && $stable(right_dbnc_ff))
        else $error("read-only write changed a setting");

    chk_wr_left_only: assert property (
        reg_wr_i && (reg_addr_i == `AGCDB_ADDR_LEFT_DBNC) |=>
        $stable(right_dbnc_ff))
        else $error("left write changed right setting");

    chk_left_quiet: assert property (
        s_rd(`AGCDB_ADDR_FLAGS) |=>
        reg_rdata_o[`AGCDB_FLAG_L_QUIET] == $past(left_quiet, 2))
        else $error("left silence flag wrong");

    chk_right_quiet: assert property (
        s_rd(`AGCDB_ADDR_FLAGS) |=>
        reg_rdata_o[`AGCDB_FLAG_R_QUIET] == $past(right_quiet, 2))
        else $error("right silence flag wrong");

    chk_left_sat_live: assert property (
        left_chan_i.max_gain <= `AGCDB_MAX_GAIN_CLAMP |=>
        flags_ff[`AGCDB_FLAG_L_SAT] ==
        $past($signed(left_chan_i.agc_gain) >= $signed({1'h0, left_chan_i.max_gain})))
        else $error("left saturation flag wrong");

    chk_right_sat_live: assert property (
        right_chan_i.max_gain <= `AGCDB_MAX_GAIN_CLAMP |=>
        flags_ff[`AGCDB_FLAG_R_SAT] ==
        $past($signed(right_chan_i.agc_gain) >= $signed({1'h0, right_chan_i.max_gain})))
        else $error("right saturation flag wrong");

    chk_sat_clamp: assert property (
        right_chan_i.max_gain > `AGCDB_MAX_GAIN_CLAMP |=>
        flags_ff[`AGCDB_FLAG_R_SAT] == $past($signed(right_chan_i.agc_gain) >= 8'sh77))
        else $error("gain limit not clamped");

    chk_tick_spacing: assert property (
        tick |=>
        !tick)
        else $error("tick lasted two cycles");

    chk_tick_fast: assert property (
        double_rate_audio_mode_i && tick_cnt_ff == TICK_W'(HALF_MS_CYCLES / 2 - 1) |->
        tick)
        else $error("double-rate tick missed");

    chk_tick_slow: assert property (
        !double_rate_audio_mode_i && tick |->
        tick_cnt_ff == TICK_W'(HALF_MS_CYCLES - 1))
        else $error("normal-rate tick early");

endmodule

//--- common/agcdb_defines.svh
`ifndef AGCDB_DEFINES_SVH
`define AGCDB_DEFINES_SVH

// ----------------------------------------------------------------------------
// register addresses on the control serial bus (page 0)
// ----------------------------------------------------------------------------
`define AGCDB_ADDR_W 7
`define AGCDB_DATA_W 8
`define AGCDB_ADDR_RIGHT_GAIN 7'h21
`define AGCDB_ADDR_LEFT_DBNC 7'h22
`define AGCDB_ADDR_RIGHT_DBNC 7'h23
`define AGCDB_ADDR_FLAGS 7'h24

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define AGCDB_RST_RIGHT_GAIN 8'h00
`define AGCDB_RST_DBNC 8'h00
`define AGCDB_RST_FLAGS 8'h00
`define AGCDB_RDATA_NONE 8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define AGCDB_NOISE_MSB 7
`define AGCDB_NOISE_LSB 3
`define AGCDB_SIG_MSB 2
`define AGCDB_SIG_LSB 0
`define AGCDB_FLAG_L_PGA 7
`define AGCDB_FLAG_L_PWR 6
`define AGCDB_FLAG_L_QUIET 5
`define AGCDB_FLAG_L_SAT 4
`define AGCDB_FLAG_R_PGA 3
`define AGCDB_FLAG_R_PWR 2
`define AGCDB_FLAG_R_QUIET 1
`define AGCDB_FLAG_R_SAT 0

// ----------------------------------------------------------------------------
// gain and timing
// ----------------------------------------------------------------------------
`define AGCDB_MAX_GAIN_CLAMP 7'h77
`define AGCDB_THR_OFF 5'h00
`define AGCDB_CLK_PERIOD_NS 5
`define AGCDB_HALF_MS_NS 500000
`define AGCDB_CNT_W 12
`define AGCDB_SHORT_LAST_CODE 5'h07
`define AGCDB_LONG_BASE_CODE 5'h07
`define AGCDB_LONG_CAP_CODE 5'h1E
`define AGCDB_LONG_CAP_MULT 12'h018
`define AGCDB_LONG_STEP_SHIFT 7

`endif

//--- common/agcdb_pkg.sv
`include "agcdb_defines.svh"

package agcdb_pkg;

    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] agc_gain;
        logic [6:0] max_gain;
        logic [4:0] noise_thr;
        logic [6:0] pga_prog;
        logic [6:0] pga_applied;
        logic adc_powered;
        logic below_thr;
    } agcdb_chan_s;

    typedef struct packed {
        logic [4:0] noise;
        logic [2:0] sig;
    } agcdb_dbnc_s;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // debounce code to half-millisecond ticks
    function automatic logic [`AGCDB_CNT_W-1:0] agcdb_ticks(input logic [4:0] code);
        logic [`AGCDB_CNT_W-1:0] mult;
        mult = 12'h000;
        if (code == 5'h00) begin
            return 12'h000;
        end
        if (code <= `AGCDB_SHORT_LAST_CODE) begin
            return 12'h001 << (code - 5'h01);
        end
        if (code >= `AGCDB_LONG_CAP_CODE) begin
            mult = `AGCDB_LONG_CAP_MULT;
        end else begin
            mult = {7'h00, code - `AGCDB_LONG_BASE_CODE};
        end
        return mult << `AGCDB_LONG_STEP_SHIFT;
    endfunction

    // applied gain at or above the clamped limit
    function automatic logic agcdb_saturated(input logic [7:0] gain, input logic [6:0] lim);
        logic [6:0] lim_c;
        lim_c = (lim > `AGCDB_MAX_GAIN_CLAMP) ? `AGCDB_MAX_GAIN_CLAMP : lim;
        return $signed(gain) >= $signed({1'b0, lim_c});
    endfunction

endpackage

//--- rtl/agcdb_debounce.sv
`timescale 1ns/10ps
`include "agcdb_defines.svh"

module agcdb_debounce (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic tick_i,
    input wire logic detect_en_i,
    input wire logic quiet_i,
    input wire logic [4:0] noise_code_i,
    input wire logic [2:0] sig_code_i,
    output logic quiet_o
);
    import agcdb_pkg::*;

    logic [`AGCDB_CNT_W-1:0] cnt_ff;
    logic quiet_ff;
    logic [`AGCDB_CNT_W-1:0] target;

    // ------------------------------------------------------------------------
    // qualification time for the pending direction
    // ------------------------------------------------------------------------
    always_comb begin
        if (quiet_i) begin
            target = agcdb_ticks(noise_code_i);
        end else begin
            target = agcdb_ticks({2'b00, sig_code_i});
        end
    end

    // ------------------------------------------------------------------------
    // state; a disagreement must persist for the whole time before it is taken
    // the first tick is partial, so the time is met to within one tick
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_ff <= 12'h000;
            quiet_ff <= 1'b0;
        end else if (!detect_en_i) begin
            cnt_ff <= 12'h000;
            quiet_ff <= 1'b0;
        end else if (quiet_i == quiet_ff) begin
            cnt_ff <= 12'h000;
        end else if (cnt_ff >= target) begin
            cnt_ff <= 12'h000;
            quiet_ff <= quiet_i;
        end else if (tick_i) begin
            cnt_ff <= cnt_ff + 12'h001;
        end
    end

    assign quiet_o = quiet_ff;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    chk_dbnc_disable: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !detect_en_i |=> !quiet_o)
        else $error("detection flag set while detection is off");

    chk_dbnc_wait: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        $changed(quiet_o) && $past(detect_en_i) |-> $past(cnt_ff >= target))
        else $error("detection flag changed before its debounce time");

endmodule

//--- verification/agcdb_host.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// host side of the register port
// ----------------------------------------------------------------------------
module agcdb_host (
    input wire logic sys_clk_i,
    output logic [6:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    initial begin
        reg_addr_o = 7'h00;
        reg_wr_o = 1'h0;
        reg_rd_o = 1'h0;
        reg_wdata_o = 8'h00;
    end

    // released lines show the inverse so a stale value never looks valid
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'h1;
        @(negedge sys_clk_i);
        reg_wr_o = 1'h0;
        reg_wdata_o = ~d;
        reg_addr_o = ~a;
    endtask

    // answer is registered on the taking edge and sampled at the falling edge half a cycle later
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'h1;
        @(negedge sys_clk_i);
        reg_rd_o = 1'h0;
        reg_addr_o = ~a;
        ok = reg_rvalid_i;
        d = reg_rdata_i;
    endtask

    // write, then read the same register at the very next edge
    task automatic wrrd(input logic [6:0] a, input logic [7:0] d, output logic [7:0] q,
        output logic ok);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'h1;
        @(negedge sys_clk_i);
        reg_wr_o = 1'h0;
        reg_rd_o = 1'h1;
        @(negedge sys_clk_i);
        reg_rd_o = 1'h0;
        reg_addr_o = ~a;
        ok = reg_rvalid_i;
        q = reg_rdata_i;
    endtask
endmodule

//--- verification/tb_top.sv
`timescale 1ns/10ps
`include "agcdb_defines.svh"

module tb_top;
    import agcdb_pkg::*;
    localparam int H = 8;
    logic sys_clk = 1'h0;
    logic arst_n = 1'h0;
    logic double_rate_audio_mode = 1'h0;
    logic [6:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    agcdb_chan_s lc = '0;
    agcdb_chan_s rc = '0;
    logic [7:0] lf = 8'h35;
    int miscompares = 0;
    int tests_run = 0;

    always #2.5 sys_clk = ~sys_clk;

    agcdb_top #(.HALF_MS_CYCLES(H)) u_agcdb_top (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .double_rate_audio_mode_i(double_rate_audio_mode),
        .left_chan_i(lc), .right_chan_i(rc));
    agcdb_host u_agcdb_host (.sys_clk_i(sys_clk), .reg_addr_o(addr), .reg_wr_o(wr),
        .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

    // ------------------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------------------
    function automatic int ticks(input int c);
        if (c == 0) return 0;
        if (c <= 7) return 1 << (c - 1);
        if (c >= 30) return 3072;
        return (c - 7) * 128;
    endfunction

    function automatic logic sat(input agcdb_chan_s c);
        int lim;
        int g;
        lim = (int'(c.max_gain) > 119) ? 119 : int'(c.max_gain);
        g = int'($signed(c.agc_gain));
        return g >= lim;
    endfunction

    function automatic logic [7:0] flags_of(input agcdb_chan_s l, input agcdb_chan_s r);
        return {l.pga_applied == l.pga_prog, l.adc_powered, 1'h0, sat(l),
                r.pga_applied == r.pga_prog, r.adc_powered, 1'h0, sat(r)};
    endfunction

    task automatic rnd(output logic [7:0] v);
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        v = lf;
    endtask

    task automatic rand_chan(output agcdb_chan_s c);
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] p;
        logic [7:0] q;
        rnd(a);
        rnd(b);
        rnd(p);
        rnd(q);
        c.agc_gain = 8'(int'(a % 144) - 24);
        c.max_gain = b[6:0];
        c.noise_thr = 5'h00;
        c.pga_prog = p[6:0];
        c.pga_applied = p[7] ? p[6:0] : q[6:0];
        c.adc_powered = q[7];
        c.below_thr = b[7];
    endtask

    // ------------------------------------------------------------------------
    // checking
    // ------------------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        u_agcdb_host.rd(a, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d, exp);
    endtask

    task automatic flag_bit(input int ch, input logic exp);
        logic [7:0] d;
        logic ok;
        u_agcdb_host.rd(`AGCDB_ADDR_FLAGS, d, ok);
        check({7'h00, d[ch == 0 ? 5 : 1]}, {7'h00, exp});
    endtask

    task automatic set_raw(input int ch, input logic b);
        if (ch == 0) begin
            lc.noise_thr = 5'h01;
            lc.below_thr = b;
        end else begin
            rc.noise_thr = 5'h01;
            rc.below_thr = b;
        end
    endtask

    // timing is accurate to one tick, so check one tick early and one late
    task automatic edge_case(input int ch, input logic b, input int t, input int hd);
        int e;
        e = (t >= 2) ? (t - 1) * hd - 4 : 0;
        set_raw(ch, b);
        repeat (e) @(negedge sys_clk);
        if (t >= 2) flag_bit(ch, ~b);
        repeat (t * hd + 8 - e) @(negedge sys_clk);
        flag_bit(ch, b);
    endtask

    task automatic quiet_case(input int ch, input int nc, input int sc, input logic d);
        int hd;
        hd = d ? H / 2 : H;
        double_rate_audio_mode = d;
        u_agcdb_host.wr(ch == 0 ? `AGCDB_ADDR_LEFT_DBNC : `AGCDB_ADDR_RIGHT_DBNC,
            {nc[4:0], sc[2:0]});
        set_raw(ch, 1'h0);
        repeat (4) @(negedge sys_clk);
        edge_case(ch, 1'h1, ticks(nc), hd);
        edge_case(ch, 1'h0, ticks(sc), hd);
        $display("silence ch %0d noise %0d signal %0d double %0d done", ch, nc, sc, d);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------------
    initial begin
        logic [7:0] v;
        logic [7:0] d;
        logic ok;
        repeat (4) @(posedge sys_clk);
        #1;
        check(rdata, 8'h00);
        check({7'h00, rvalid}, 8'h00);
        @(negedge sys_clk);
        arst_n = 1'h1;
        rdc(`AGCDB_ADDR_RIGHT_GAIN, 8'h00);
        rdc(`AGCDB_ADDR_LEFT_DBNC, 8'h00);
        rdc(`AGCDB_ADDR_RIGHT_DBNC, 8'h00);
        rdc(`AGCDB_ADDR_FLAGS, flags_of(lc, rc));
        rdc(7'h20, 8'h00);
        u_agcdb_host.wr(`AGCDB_ADDR_RIGHT_GAIN, 8'hFF);
        u_agcdb_host.wr(`AGCDB_ADDR_FLAGS, 8'hFF);
        rdc(`AGCDB_ADDR_RIGHT_GAIN, 8'h00);
        rdc(`AGCDB_ADDR_FLAGS, flags_of(lc, rc));
        $display("reset and read-only test done");
        for (int i = 0; i < 4; i++) begin
            rnd(v);
            u_agcdb_host.wrrd(`AGCDB_ADDR_LEFT_DBNC, v, d, ok);
            check({7'h00, ok}, 8'h01);
            check(d, v);
            u_agcdb_host.wrrd(`AGCDB_ADDR_RIGHT_DBNC, ~v, d, ok);
            check({7'h00, ok}, 8'h01);
            check(d, ~v);
            rdc(`AGCDB_ADDR_LEFT_DBNC, v);
        end
        $display("debounce register test done");
        // zero threshold keeps silence flags low whatever the raw detector says
        for (int i = 0; i < 24; i++) begin
            rand_chan(lc);
            rand_chan(rc);
            rdc(`AGCDB_ADDR_FLAGS, flags_of(lc, rc));
            rdc(`AGCDB_ADDR_FLAGS, flags_of(lc, rc));
            rdc(`AGCDB_ADDR_RIGHT_GAIN, rc.agc_gain);
        end
        $display("status flag test done");
        quiet_case(0, 0, 0, 1'h0);
        quiet_case(0, 1, 2, 1'h0);
        quiet_case(1, 3, 7, 1'h0);
        quiet_case(1, 8, 1, 1'h1);
        quiet_case(0, 9, 3, 1'h1);
        quiet_case(1, 30, 0, 1'h1);
        complete_run();
    end

    initial begin
        #500000;
        miscompares++;
        complete_run();
    end
endmodule
